// file: design/mcg_clock_gen.sv
// Main clock generator: source select, CPU and bus dividers, module clock gates,
// prescaled bus clock gates, lock-and-key write protection, clock-ready flag.
// Assumes source ticks come from logic on CLK; bus access is one cycle per strobe.
`include "mcg_defines.svh"

// Function
// - Main tick follows the source chosen by the 3-bit main source field.
// - Protected registers accept a write only right after a matching unlock write.
// - CPU tick is main tick, or main divided by 2^(select+1) when enabled.
// - Writing CPU or peripheral divider registers clears the clock-ready flag.
// - High-speed divider register is read-only and mirrors the CPU divider.
// - Each peripheral bus tick is main or main divided by 2^(select+1).
// - A cleared gate bit stops that module clock; a set bit lets it run.
// - Only listed gate bits are implemented per bus; the rest read zero.
// - Prescaled gate bit n enables the bus clock divided by 2^(n+1).
// - Unlock needs key 0xAA and target address; next access must be that write.
// - Clock-ready returns high once new divider settings are in effect.
module mcg_clock_gen
    import mcg_pkg::*;
#(
    parameter int CNT_W = `MCG_DIV_CNT_W
)
(
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic [7:0]       SRC_TICK,
    input  wire logic             PB_SEL,
    input  wire logic             PB_WRITE,
    input  wire logic [9:0]       PB_ADDR,
    input  wire logic [31:0]      PB_WDATA,
    output      logic [31:0]      PB_RDATA,
    output      logic             CLOCK_READY,
    output      logic             MAIN_CLK_EN,
    output      logic             CPU_CLK_EN,
    output      logic             HSB_CLK_EN,
    output      logic [2:0]       PB_CLK_EN,
    output      logic [31:0]      CPU_MOD_EN,
    output      logic [31:0]      HSB_MOD_EN,
    output      logic [31:0]      PBA_MOD_EN,
    output      logic [31:0]      PBB_MOD_EN,
    output      logic [31:0]      PBC_MOD_EN,
    output      logic [6:0]       PBA_DIV_EN,
    output      logic [6:0]       PBB_DIV_EN,
    output      logic [6:0]       PBC_DIV_EN
);

    if (CNT_W < `MCG_DIV_CNT_W) begin : g_check
        $error("mcg_clock_gen: CNT_W too small for divide by 256");
    end

    localparam logic [2:0][31:0] PB_GATE_IMPL = {`MCG_PBC_GATE_IMPL,
                                                 `MCG_PBB_GATE_IMPL,
                                                 `MCG_PBA_GATE_IMPL};
    localparam logic [2:0][9:0]  PB_DIV_OFS   = {`MCG_OFS_PBC_DIV,
                                                 `MCG_OFS_PBB_DIV,
                                                 `MCG_OFS_PBA_DIV};
    localparam logic [2:0][9:0]  PB_GATE_OFS  = {`MCG_OFS_PBC_GATE,
                                                 `MCG_OFS_PBB_GATE,
                                                 `MCG_OFS_PBA_GATE};
    localparam logic [2:0][9:0]  PB_PRESC_OFS = {`MCG_OFS_PBC_PRESC,
                                                 `MCG_OFS_PBB_PRESC,
                                                 `MCG_OFS_PBA_PRESC};

    mcg_top_state_t   s_reg;
    mcg_top_state_t   s_next;
    logic             main_tick;
    logic             cpu_tick;
    logic             cpu_busy;
    logic [2:0]       pb_tick;
    logic [2:0]       pb_busy;
    logic             wr_ok;
    logic [6:0]       low_ones;

    // Main source selection
    mcg_source_sel u_src (
        .clk       (CLK),
        .rst       (RST),
        .src_tick  (SRC_TICK),
        .sel       (s_reg.msel),
        .main_tick (main_tick)
    );

    // CPU divider; the high-speed bus shares it
    mcg_divider #(.CNT_W(CNT_W)) u_cpu_div (
        .clk       (CLK),
        .rst       (RST),
        .main_tick (main_tick),
        .cfg       (s_reg.cpu),
        .load      (s_reg.cpu_load),
        .tick      (cpu_tick),
        .busy      (cpu_busy)
    );

    // One divider per peripheral bus
    for (genvar g = 0; g < 3; g++) begin : g_pb
        mcg_divider #(.CNT_W(CNT_W)) u_pb_div (
            .clk       (CLK),
            .rst       (RST),
            .main_tick (main_tick),
            .cfg       (s_reg.pb[g]),
            .load      (s_reg.pb_load[g]),
            .tick      (pb_tick[g]),
            .busy      (pb_busy[g])
        );
    end

    // Register access, unlock sequencing, gating and prescaling
    always_comb begin
        s_next          = s_reg;
        s_next.cpu_load = 1'b0;
        s_next.pb_load  = '0;
        s_next.rdata    = '0;
        wr_ok           = s_reg.armed && (s_reg.unlock_addr == PB_ADDR);
        low_ones        = '0;

        if (PB_SEL) begin
            // Any access other than the arming write drops the unlock
            s_next.armed = 1'b0;
            if (PB_WRITE) begin
                if (PB_ADDR == `MCG_OFS_UNLOCK) begin
                    if (PB_WDATA[`MCG_KEY_MSB:`MCG_KEY_LSB] == `MCG_UNLOCK_KEY) begin
                        s_next.armed       = 1'b1;
                        s_next.unlock_addr = PB_WDATA[9:0];
                    end
                end else if (wr_ok) begin
                    case (PB_ADDR)
                        `MCG_OFS_MAIN_SRC: begin
                            if (PB_WDATA[2:0] != `MCG_SRC_RESERVED) begin
                                s_next.msel = PB_WDATA[2:0];
                            end
                        end
                        `MCG_OFS_CPU_DIV: begin
                            s_next.cpu.en   = PB_WDATA[`MCG_DIV_EN_BIT];
                            s_next.cpu.sel  = PB_WDATA[2:0];
                            s_next.cpu_load = 1'b1;
                        end
                        `MCG_OFS_CPU_GATE: begin
                            s_next.cpu_gate = PB_WDATA & `MCG_CPU_GATE_IMPL;
                        end
                        `MCG_OFS_HSB_GATE: begin
                            s_next.hsb_gate = PB_WDATA & `MCG_HSB_GATE_IMPL;
                        end
                        default: begin
                            for (int i = 0; i < 3; i++) begin
                                if (PB_ADDR == PB_DIV_OFS[i]) begin
                                    s_next.pb[i].en     = PB_WDATA[`MCG_DIV_EN_BIT];
                                    s_next.pb[i].sel    = PB_WDATA[2:0];
                                    s_next.pb_load[i]   = 1'b1;
                                end
                                if (PB_ADDR == PB_GATE_OFS[i]) begin
                                    s_next.pb_gate[i] = PB_WDATA & PB_GATE_IMPL[i];
                                end
                                if (PB_ADDR == PB_PRESC_OFS[i]) begin
                                    s_next.presc_gate[i] = PB_WDATA[6:0];
                                end
                            end
                        end
                    endcase
                end
            end else begin
                case (PB_ADDR)
                    `MCG_OFS_MAIN_SRC: begin
                        s_next.rdata[2:0] = s_reg.msel;
                    end
                    `MCG_OFS_CPU_DIV, `MCG_OFS_HSB_MIRROR: begin
                        s_next.rdata[`MCG_DIV_EN_BIT] = s_reg.cpu.en;
                        s_next.rdata[2:0]             = s_reg.cpu.sel;
                    end
                    `MCG_OFS_CPU_GATE: begin
                        s_next.rdata = s_reg.cpu_gate;
                    end
                    `MCG_OFS_HSB_GATE: begin
                        s_next.rdata = s_reg.hsb_gate;
                    end
                    `MCG_OFS_STATUS: begin
                        s_next.rdata[`MCG_READY_BIT] = s_reg.ready;
                    end
                    default: begin
                        for (int i = 0; i < 3; i++) begin
                            if (PB_ADDR == PB_DIV_OFS[i]) begin
                                s_next.rdata[`MCG_DIV_EN_BIT] = s_reg.pb[i].en;
                                s_next.rdata[2:0]             = s_reg.pb[i].sel;
                            end
                            if (PB_ADDR == PB_GATE_OFS[i]) begin
                                s_next.rdata = s_reg.pb_gate[i];
                            end
                            if (PB_ADDR == PB_PRESC_OFS[i]) begin
                                s_next.rdata[6:0] = s_reg.presc_gate[i];
                            end
                        end
                    end
                endcase
            end
        end

        // Ready only when no setting is queued or waiting in a divider
        s_next.ready = !(s_next.cpu_load || (|s_next.pb_load) ||
                         s_reg.cpu_load || (|s_reg.pb_load) ||
                         cpu_busy || (|pb_busy));

        // Bus ticks and module gates
        s_next.main_en = main_tick;
        s_next.cpu_en  = cpu_tick;
        s_next.hsb_en  = cpu_tick;
        s_next.pb_en   = pb_tick;
        s_next.cpu_mod = {32{cpu_tick}} & s_reg.cpu_gate;
        s_next.hsb_mod = {32{cpu_tick}} & s_reg.hsb_gate;
        for (int i = 0; i < 3; i++) begin
            s_next.pb_mod[i] = {32{pb_tick[i]}} & s_reg.pb_gate[i];
            if (pb_tick[i]) begin
                s_next.presc_cnt[i] = s_reg.presc_cnt[i] + 7'h01;
            end
            // Tap n fires once every 2^(n+1) bus ticks
            for (int k = 0; k < 7; k++) begin
                low_ones = 7'h7f >> (6 - k);
                s_next.pb_div[i][k] = pb_tick[i] && s_reg.presc_gate[i][k] &&
                                      ((s_reg.presc_cnt[i] & low_ones) == low_ones);
            end
        end
    end

    // State register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_reg            <= '0;
            s_reg.msel       <= `MCG_MAIN_SRC_RESET;
            s_reg.cpu_gate   <= `MCG_CPU_GATE_IMPL;
            s_reg.hsb_gate   <= `MCG_HSB_GATE_IMPL;
            s_reg.pb_gate    <= PB_GATE_IMPL;
            s_reg.presc_gate <= {3{`MCG_PRESC_RESET}};
            s_reg.ready      <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign PB_RDATA    = s_reg.rdata;
    assign CLOCK_READY = s_reg.ready;
    assign MAIN_CLK_EN = s_reg.main_en;
    assign CPU_CLK_EN  = s_reg.cpu_en;
    assign HSB_CLK_EN  = s_reg.hsb_en;
    assign PB_CLK_EN   = s_reg.pb_en;
    assign CPU_MOD_EN  = s_reg.cpu_mod;
    assign HSB_MOD_EN  = s_reg.hsb_mod;
    assign PBA_MOD_EN  = s_reg.pb_mod[0];
    assign PBB_MOD_EN  = s_reg.pb_mod[1];
    assign PBC_MOD_EN  = s_reg.pb_mod[2];
    assign PBA_DIV_EN  = s_reg.pb_div[0];
    assign PBB_DIV_EN  = s_reg.pb_div[1];
    assign PBC_DIV_EN  = s_reg.pb_div[2];

endmodule : mcg_clock_gen

// file: shared/mcg_defines.svh
// Register offsets, field positions, reset values and key for the main clock generator.
// Assumes byte addresses on the 10-bit peripheral bus address, one 32-bit word per register.
`ifndef MCG_DEFINES_SVH
`define MCG_DEFINES_SVH

// Register byte offsets
`define MCG_OFS_MAIN_SRC     10'h000
`define MCG_OFS_CPU_DIV      10'h004
`define MCG_OFS_HSB_MIRROR   10'h008
`define MCG_OFS_PBA_DIV      10'h00c
`define MCG_OFS_PBB_DIV      10'h010
`define MCG_OFS_PBC_DIV      10'h014
`define MCG_OFS_CPU_GATE     10'h020
`define MCG_OFS_HSB_GATE     10'h024
`define MCG_OFS_PBA_GATE     10'h028
`define MCG_OFS_PBB_GATE     10'h02c
`define MCG_OFS_PBC_GATE     10'h030
`define MCG_OFS_PBA_PRESC    10'h040
`define MCG_OFS_PBB_PRESC    10'h044
`define MCG_OFS_PBC_PRESC    10'h048
`define MCG_OFS_UNLOCK       10'h058
`define MCG_OFS_STATUS       10'h0d4

// Field positions
`define MCG_DIV_EN_BIT       7
`define MCG_READY_BIT        5
`define MCG_KEY_MSB          31
`define MCG_KEY_LSB          24
`define MCG_UNLOCK_KEY       8'haa

// Main source encoding that software may not select
`define MCG_SRC_RESERVED     3'h6

// Implemented gate bits; every implemented bit resets to one
`define MCG_CPU_GATE_IMPL    32'h00000002
`define MCG_HSB_GATE_IMPL    32'h00001fff
`define MCG_PBA_GATE_IMPL    32'h07ffffff
`define MCG_PBB_GATE_IMPL    32'h0000007f
`define MCG_PBC_GATE_IMPL    32'h000003ff
`define MCG_PRESC_RESET      7'h7f
`define MCG_MAIN_SRC_RESET   3'h0

// Divider counter width: 2^(7+1) needs eight bits
`define MCG_DIV_CNT_W        8

`endif

// file: shared/mcg_pkg.sv
// Types shared by the main clock generator modules.
// Assumes mcg_defines.svh is on the include path.
`include "mcg_defines.svh"

package mcg_pkg;

    // One divider setting: divide enable and power-of-two select
    typedef struct packed {
        logic       en;
        logic [2:0] sel;
    } mcg_div_cfg_t;

    // State of the glitch-free source selector
    typedef struct packed {
        logic [2:0] active;
        logic       tick;
    } mcg_src_state_t;

    // State of one bus divider
    typedef struct packed {
        logic [`MCG_DIV_CNT_W-1:0] cnt;
        mcg_div_cfg_t              act;
        mcg_div_cfg_t              pend_cfg;
        logic                      pend;
        logic                      tick;
    } mcg_div_state_t;

    // State of the top level
    typedef struct packed {
        logic [2:0]            msel;
        mcg_div_cfg_t          cpu;
        mcg_div_cfg_t [2:0]    pb;
        logic [31:0]           cpu_gate;
        logic [31:0]           hsb_gate;
        logic [2:0][31:0]      pb_gate;
        logic [2:0][6:0]       presc_gate;
        logic                  armed;
        logic [9:0]            unlock_addr;
        logic [2:0][6:0]       presc_cnt;
        logic                  cpu_load;
        logic [2:0]            pb_load;
        logic                  ready;
        logic [31:0]           rdata;
        logic                  main_en;
        logic                  cpu_en;
        logic                  hsb_en;
        logic [2:0]            pb_en;
        logic [31:0]           cpu_mod;
        logic [31:0]           hsb_mod;
        logic [2:0][31:0]      pb_mod;
        logic [2:0][6:0]       pb_div;
    } mcg_top_state_t;

endpackage : mcg_pkg

// file: design/mcg_source_sel.sv
// Glitch-free selector of the main clock tick among eight source ticks.
// Assumes source ticks are one-cycle enables from logic on CLK.
module mcg_source_sel
    import mcg_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] src_tick,
    input  wire logic [2:0] sel,
    output      logic       main_tick
);

    mcg_src_state_t s_reg;
    mcg_src_state_t s_next;

    // Follow the active source; move to a new one only on a tick of the old one
    always_comb begin
        s_next      = s_reg;
        s_next.tick = src_tick[s_reg.active];
        if (src_tick[s_reg.active] && (sel != s_reg.active)) begin
            s_next.active = sel;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{active: `MCG_MAIN_SRC_RESET, tick: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign main_tick = s_reg.tick;

endmodule : mcg_source_sel

// file: design/mcg_divider.sv
// Power-of-two tick divider with a setting that changes only at a period boundary.
// Assumes main_tick is a one-cycle enable on clk; load pulses for one cycle.
module mcg_divider
    import mcg_pkg::*;
#(
    parameter int CNT_W = `MCG_DIV_CNT_W
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         main_tick,
    input  wire mcg_div_cfg_t cfg,
    input  wire logic         load,
    output      logic         tick,
    output      logic         busy
);

    if (CNT_W < `MCG_DIV_CNT_W) begin : g_check
        $error("mcg_divider: CNT_W too small for divide by 256");
    end

    mcg_div_state_t       s_reg;
    mcg_div_state_t       s_next;
    logic [CNT_W-1:0]     lim;
    logic                 boundary;

    // Count main ticks, emit one tick per period, swap settings at the boundary
    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        lim         = {CNT_W{1'b1}} >> (CNT_W - 1 - int'(s_reg.act.sel));
        boundary    = main_tick && (!s_reg.act.en || (s_reg.cnt == lim));
        if (main_tick) begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
        if (boundary) begin
            s_next.tick = 1'b1;
            s_next.cnt  = '0;
            if (s_reg.pend) begin
                s_next.act  = s_reg.pend_cfg;
                s_next.pend = 1'b0;
            end
        end
        if (load) begin
            s_next.pend_cfg = cfg;
            s_next.pend     = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
    assign busy = s_reg.pend;

endmodule : mcg_divider

// file: test/mcg_clock_gen_monitor.sv
// Port checker for the main clock generator.
// Assumes every port is on CLK, with RST as the asynchronous reset.
`include "mcg_defines.svh"
module mcg_clock_gen_monitor
    import mcg_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [7:0]  SRC_TICK,
    input wire logic        PB_SEL,
    input wire logic        PB_WRITE,
    input wire logic [9:0]  PB_ADDR,
    input wire logic [31:0] PB_WDATA,
    input wire logic [31:0] PB_RDATA,
    input wire logic        CLOCK_READY,
    input wire logic        MAIN_CLK_EN,
    input wire logic        CPU_CLK_EN,
    input wire logic        HSB_CLK_EN,
    input wire logic [2:0]  PB_CLK_EN,
    input wire logic [31:0] CPU_MOD_EN,
    input wire logic [31:0] PBA_MOD_EN
);
    timeunit 1ns;
    timeprecision 1ns;
    // One clock, checks paused in reset
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_rdy_clr;
        PB_SEL && PB_WRITE && PB_ADDR inside {10'h004, 10'h00c, 10'h010, 10'h014}
            && $past(PB_SEL && PB_WRITE && PB_ADDR == 10'h058 && PB_WDATA[31:24] == 8'haa)
            && $past(PB_WDATA[9:0]) == PB_ADDR |=> !CLOCK_READY;
    endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready kept");
    property p_rdy_back;
        $fell(CLOCK_READY) |-> ##[1:1000] CLOCK_READY;
    endproperty
    a_rdy_back: assert property (p_rdy_back) else $error("ready stuck low");
    property p_mirror;
        PB_SEL && !PB_WRITE && PB_ADDR == 10'h008
            |=> PB_RDATA[31:8] == 24'h0 && PB_RDATA[6:3] == 4'h0;
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror extra bits");
    property p_src;
        MAIN_CLK_EN |-> ($past(SRC_TICK, 2) & 8'hbf) != 8'h00;
    endproperty
    a_src: assert property (p_src) else $error("main tick without source");
    property p_cpu;
        CPU_CLK_EN |-> $past(MAIN_CLK_EN);
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu tick off main");
    property p_hsb;
        HSB_CLK_EN == CPU_CLK_EN;
    endproperty
    a_hsb: assert property (p_hsb) else $error("hsb tick differs");
    property p_pb;
        PB_CLK_EN != 3'h0 |-> $past(MAIN_CLK_EN);
    endproperty
    a_pb: assert property (p_pb) else $error("bus tick off main");
    property p_cpu_gate;
        (CPU_MOD_EN & ~({32{CPU_CLK_EN}} & `MCG_CPU_GATE_IMPL)) == 32'h0;
    endproperty
    a_cpu_gate: assert property (p_cpu_gate) else $error("cpu module clock");
    property p_pba_gate;
        (PBA_MOD_EN & ~({32{PB_CLK_EN[0]}} & `MCG_PBA_GATE_IMPL)) == 32'h0;
    endproperty
    a_pba_gate: assert property (p_pba_gate) else $error("bus a module clock");
endmodule : mcg_clock_gen_monitor

bind mcg_clock_gen mcg_clock_gen_monitor #(.CNT_W(CNT_W)) i_mcg_clock_gen_monitor (
    .CLK(CLK), .RST(RST), .SRC_TICK(SRC_TICK), .PB_SEL(PB_SEL), .PB_WRITE(PB_WRITE),
    .PB_ADDR(PB_ADDR), .PB_WDATA(PB_WDATA), .PB_RDATA(PB_RDATA),
    .CLOCK_READY(CLOCK_READY), .MAIN_CLK_EN(MAIN_CLK_EN), .CPU_CLK_EN(CPU_CLK_EN),
    .HSB_CLK_EN(HSB_CLK_EN), .PB_CLK_EN(PB_CLK_EN), .CPU_MOD_EN(CPU_MOD_EN),
    .PBA_MOD_EN(PBA_MOD_EN));

// file: test/tb_top.sv
// Self-checking bench: registers, lock, sources, dividers, gates.
// Assumes the design, its package and the bound checker compile first.
module tb_top
    import mcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, sel = 1'b0, wr = 1'b0, rd_flag = 1'b0;
    logic [7:0]  tick = 8'h00;
    logic [9:0]  addr = 10'h000;
    logic [31:0] wd = 32'h0;
    logic [7:0]  hist = 8'h0;
    logic [31:0] expq [$];
    int          fail_count, compares, cyc;
    wire logic [31:0] rdata;
    wire logic        rdy, main_en, cpu_en, hsb_en;
    wire logic [2:0]  pb_en;
    wire logic [31:0] mod [5];
    wire logic [6:0]  dv [3];
    localparam logic [9:0] RA [16] = '{10'h000, 10'h004, 10'h008, 10'h00c, 10'h010,
        10'h014, 10'h020, 10'h024, 10'h028, 10'h02c, 10'h030, 10'h040, 10'h044,
        10'h048, 10'h0d4, 10'h100};
    localparam logic [31:0] RE [16] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h2, 32'h1fff, 32'h07ffffff, 32'h7f, 32'h3ff, 32'h7f, 32'h7f, 32'h7f,
        32'h20, 32'h0};
    localparam logic [9:0] DA [4] = '{10'h004, 10'h00c, 10'h010, 10'h014};
    localparam int SRC [7] = '{1, 2, 3, 4, 5, 7, 0};
    mcg_clock_gen #(.CNT_W(8)) i_mcg_clock_gen (
        .CLK(clk), .RST(rst), .SRC_TICK(tick), .PB_SEL(sel), .PB_WRITE(wr),
        .PB_ADDR(addr), .PB_WDATA(wd), .PB_RDATA(rdata), .CLOCK_READY(rdy),
        .MAIN_CLK_EN(main_en), .CPU_CLK_EN(cpu_en), .HSB_CLK_EN(hsb_en),
        .PB_CLK_EN(pb_en), .CPU_MOD_EN(mod[0]), .HSB_MOD_EN(mod[1]),
        .PBA_MOD_EN(mod[2]), .PBB_MOD_EN(mod[3]), .PBC_MOD_EN(mod[4]),
        .PBA_DIV_EN(dv[0]), .PBB_DIV_EN(dv[1]), .PBC_DIV_EN(dv[2]));
    // 10 MHz clock
    initial begin
        forever #50 clk = ~clk;
    end
    // Counts and reports one comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    // One access; the strobe stays up until idle or the next access
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
        sel = 1'b1;
        wr = w;
        addr = a;
        wd = d;
        @(negedge clk);
    endtask : acc
    task automatic idle;
        sel = 1'b0;
        @(negedge clk);
    endtask : idle
    // Read, noting the expected data for the watcher
    task automatic rd_exp(input logic [9:0] a, input logic [31:0] e);
        expq.push_back(e);
        acc(1'b0, a, 32'h0);
    endtask : rd_exp
    // Unlock a target, then write it as the next access
    task automatic uw(input logic [9:0] a, input logic [31:0] d);
        acc(1'b1, 10'h058, {8'haa, 14'h0, a});
        acc(1'b1, a, d);
    endtask : uw
    task automatic wait_rdy;
        int t;
        t = 0;
        while (rdy !== 1'b1 && t < 3000) begin
            @(negedge clk);
            t++;
        end
    endtask : wait_rdy
    function automatic logic pick(input int k);
        case (k)
            0: return cpu_en;
            1, 2, 3: return pb_en[k - 1];
            default: return dv[0][k - 4];
        endcase
    endfunction : pick
    // Unit ticks between two pulses: main ticks (one cycle ahead of bus ticks),
    // or bus A ticks for prescaled taps, which share the bus tick's cycle
    task automatic span(input int k, output int n);
        int t;
        logic pm;
        n = 0;
        t = 0;
        while (pick(k) !== 1'b1 && t < 3000) begin
            @(negedge clk);
            t++;
        end
        do begin
            pm = main_en;
            @(negedge clk);
            t++;
            if ((k < 4 ? pm : pb_en[0]) === 1'b1) n++;
        end while (pick(k) !== 1'b1 && t < 3000);
    endtask : span
    // Random source ticks with history; read data against the oldest note
    always @(posedge clk) rd_flag <= sel & ~wr;
    always @(negedge clk) begin
        hist <= tick;
        tick <= 8'($urandom);
        if (rd_flag && expq.size() > 0) check(rdata, expq.pop_front());
    end
    // Cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        logic [31:0] r, ac;
        logic pm;
        int n, s;
        void'($urandom(69432));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) rd_exp(RA[i], RE[i]);
        idle();
        $display("test reset_values done");
        // Plain write, read between, wrong key, idle between
        acc(1'b1, 10'h020, 32'h0);
        rd_exp(10'h020, 32'h2);
        acc(1'b1, 10'h058, {8'haa, 14'h0, 10'h020});
        rd_exp(10'h058, 32'h0);
        acc(1'b1, 10'h020, 32'h0);
        rd_exp(10'h020, 32'h2);
        acc(1'b1, 10'h058, {8'h55, 14'h0, 10'h020});
        acc(1'b1, 10'h020, 32'h0);
        rd_exp(10'h020, 32'h2);
        acc(1'b1, 10'h058, {8'haa, 14'h0, 10'h020});
        idle();
        acc(1'b1, 10'h020, 32'h0);
        rd_exp(10'h020, 32'h0);
        idle();
        $display("test lock done");
        // Random gate values; outputs follow the undivided bus ticks
        for (int i = 6; i < 14; i++) begin
            r = $urandom;
            uw(RA[i], r);
            rd_exp(RA[i], r & RE[i]);
            idle();
            ac = 32'h0;
            pm = main_en;
            repeat (40) begin
                @(negedge clk);
                if (i < 11) check(mod[i - 6], pm === 1'b1 ? r & RE[i] : 32'h0);
                if (i > 10) ac = ac | dv[i - 11];
                pm = main_en;
            end
            if (i > 10) check(ac & ~r, 32'h0);
        end
        $display("test gates done");
        // Every selectable source; the reserved code is dropped
        foreach (SRC[j]) begin
            uw(10'h000, 32'(SRC[j]));
            uw(10'h000, 32'h6);
            rd_exp(10'h000, 32'(SRC[j]));
            idle();
            repeat (30) @(negedge clk);
            repeat (16) begin
                @(negedge clk);
                check(main_en, hist[SRC[j]]);
            end
        end
        $display("test sources done");
        // Each divider: ready drops and returns, period, mirror, undivided again
        for (int k = 0; k < 4; k++) begin
            s = $urandom_range(2, 0);
            uw(DA[k], 32'h80 | s);
            check(rdy, 1'b0);
            idle();
            wait_rdy();
            check(rdy, 1'b1);
            rd_exp(DA[k], 32'h80 | s);
            span(k, n);
            check(n, 2 << s);
            if (k == 0) begin
                uw(10'h008, 32'h0);
                rd_exp(10'h008, 32'h80 | s);
            end
            if (k == 1) begin
                uw(10'h040, 32'h7f);
                for (int b = 0; b < 2; b++) begin
                    span(4 + b, n);
                    check(n, 2 << b);
                end
            end
            uw(DA[k], 32'h0);
            idle();
            wait_rdy();
            span(k, n);
            check(n, 1);
        end
        $display("test dividers done");
        test_done();
    end
endmodule : tb_top
